// File: rtl/sdc_spi_regs.v
`timescale 1ns/1ps
`include "sdc_regs.vh"

// Function
// - function registers 0x08..0x3E are shadowed; writes wait for a transfer.
// - writing 0x01 to 0xFF copies all shadow values to active at once.
// - the transfer bit clears itself after the copy.
// - local registers have one copy per channel.
// - channel-select bits in 0x05 steer local access, bit0 A, bit1 B.
// - with several channels selected, a write updates every selected copy.
// - host reads with one channel selected; several selected returns channel A.
// - global registers ignore the channel-select bits, except port config, which is written only with both A and B selected.
// - port config mirrors soft-reset and LSB-first in both nibbles; resets to 0x18.
// - every reset loads the configuration registers with defaults.
// - each access is a 16-bit instruction then 8-bit data words.
module sdc_spi_regs #(
    parameter [7:0] DEVICE_IDENTIFIER = 8'h5C // arbitrary identification value
) (
    input wire clk,
    input wire rstn,
    input wire spiSclk,
    input wire spiCsN,
    input wire sdioIn,
    output reg sdioOut,
    output reg sdioOe,
    output reg lsbFirst_reg,
    output reg [7:0] chanSel_reg,
    output wire [8*`SDC_FUNC_COUNT-1:0] activeA,
    output wire [8*`SDC_FUNC_COUNT-1:0] activeB
);
    // ======================================================
    // storage
    reg [7:0] shadowA [0:`SDC_FUNC_COUNT-1];
    reg [7:0] shadowB [0:`SDC_FUNC_COUNT-1];
    reg [7:0] actA [0:`SDC_FUNC_COUNT-1];
    reg [7:0] actB [0:`SDC_FUNC_COUNT-1];
    reg commit_reg;
    reg softRst_reg;

    // frame state
    reg sclkPrev_reg;
    reg [4:0] bitCnt_reg;
    reg inData_reg;
    reg isRead_reg;
    reg [12:0] addr_reg;
    reg [15:0] rxSr_reg;
    reg [7:0] txSr_reg;

    wire [2:0] syncBus;
    wire sclkS;
    wire csNS;
    wire sdioS;
    wire sclkRise;
    wire sclkFall;
    wire [15:0] rxNext;
    wire [7:0] rxByte;
    wire byteDone;
    wire instrDone;
    wire wrStrobe;
    integer i;
    genvar g;

    // ======================================================
    // helpers
    function isFunc;
        input [12:0] a;
        begin
            isFunc = (a >= `SDC_ADDR_FUNC_FIRST) && (a <= `SDC_ADDR_FUNC_LAST);
        end
    endfunction

    function [5:0] funcIdx;
        input [12:0] a;
        reg [12:0] d;
        begin
            // full-width subtract, then keep the index bits on purpose
            d = a - `SDC_ADDR_FUNC_FIRST;
            funcIdx = d[5:0];
        end
    endfunction

    function [7:0] funcDefault;
        input [12:0] a;
        begin
            if (a == `SDC_ADDR_SHUFFLE)
                funcDefault = `SDC_SHUFFLE_RESET;
            else
                funcDefault = `SDC_FUNC_RESET;
        end
    endfunction

    // streaming walks down in msb-first mode and up in lsb-first mode
    function [12:0] stepAddr;
        input [12:0] a;
        input up;
        begin
            stepAddr = up ? a + 13'h0001 : a - 13'h0001;
        end
    endfunction

    function [7:0] readByte;
        input [12:0] a;
        reg [5:0] k;
        begin
            k = funcIdx(a);
            readByte = 8'h00;
            if (a == `SDC_ADDR_PORT_CFG)
                readByte = `SDC_CFG_FIXED_MASK |
                    {1'b0, lsbFirst_reg, 4'h0, lsbFirst_reg, 1'b0};
            else if (a == `SDC_ADDR_DEVICE_IDENTIFIER)
                readByte = DEVICE_IDENTIFIER;
            else if (a == `SDC_ADDR_CHAN_SEL)
                readByte = chanSel_reg;
            else if (a == `SDC_ADDR_COMMIT)
                readByte = {7'h00, commit_reg};
            else if (isFunc(a) && (a == `SDC_ADDR_FUNC_GLOBAL || chanSel_reg[`SDC_SEL_A]))
                readByte = shadowA[k];
            else if (isFunc(a) && chanSel_reg[`SDC_SEL_B])
                readByte = shadowB[k];
        end
    endfunction

    // ======================================================
    // pin sampling; chip select idles high
    sdc_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h2)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .dIn({spiSclk, spiCsN, sdioIn}),
        .dOut(syncBus)
    );

    assign sclkS = syncBus[2];
    assign csNS = syncBus[1];
    assign sdioS = syncBus[0];
    assign sclkRise = sclkS & ~sclkPrev_reg & ~csNS;
    assign sclkFall = ~sclkS & sclkPrev_reg & ~csNS;

    // lsb-first shifts right so the r/w bit always lands in bit 15
    assign rxNext = lsbFirst_reg ? {sdioS, rxSr_reg[15:1]} : {rxSr_reg[14:0], sdioS};
    assign rxByte = lsbFirst_reg ? rxNext[15:8] : rxNext[7:0];
    assign instrDone = sclkRise & ~inData_reg & (bitCnt_reg == `SDC_INSTR_LAST);
    assign byteDone = sclkRise & inData_reg & (bitCnt_reg == `SDC_BYTE_LAST);
    assign wrStrobe = byteDone & ~isRead_reg;

    // ======================================================
    // serial frame engine
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg <= 5'h00;
            inData_reg <= 1'b0;
            isRead_reg <= 1'b0;
            addr_reg <= 13'h0000;
            rxSr_reg <= 16'h0000;
            txSr_reg <= 8'h00;
            sdioOut <= 1'b0;
            sdioOe <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkS;
            if (csNS) begin
                // frame ends; release the pin at once
                bitCnt_reg <= 5'h00;
                inData_reg <= 1'b0;
                sdioOe <= 1'b0;
            end else if (sclkRise) begin
                rxSr_reg <= rxNext;
                if (instrDone) begin
                    inData_reg <= 1'b1;
                    isRead_reg <= rxNext[`SDC_INSTR_RW];
                    addr_reg <= rxNext[12:0];
                    txSr_reg <= readByte(rxNext[12:0]);
                    bitCnt_reg <= 5'h00;
                end else if (byteDone) begin
                    addr_reg <= stepAddr(addr_reg, lsbFirst_reg);
                    txSr_reg <= readByte(stepAddr(addr_reg, lsbFirst_reg));
                    bitCnt_reg <= 5'h00;
                end else begin
                    bitCnt_reg <= bitCnt_reg + 5'h01;
                end
            end else if (sclkFall && inData_reg && isRead_reg) begin
                // drive on the falling edge so the host samples on the rise
                sdioOe <= 1'b1;
                sdioOut <= lsbFirst_reg ? txSr_reg[0] : txSr_reg[7];
                txSr_reg <= lsbFirst_reg ? {1'b0, txSr_reg[7:1]} : {txSr_reg[6:0], 1'b0};
            end
        end
    end

    // ======================================================
    // register bank
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lsbFirst_reg <= 1'b0;
            chanSel_reg <= `SDC_CHAN_SEL_RESET;
            commit_reg <= 1'b0;
            softRst_reg <= 1'b0;
            for (i = 0; i < `SDC_FUNC_COUNT; i = i + 1) begin
                shadowA[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                shadowB[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                actA[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                actB[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
            end
        end else if (softRst_reg) begin
            lsbFirst_reg <= 1'b0;
            chanSel_reg <= `SDC_CHAN_SEL_RESET;
            commit_reg <= 1'b0;
            softRst_reg <= 1'b0;
            for (i = 0; i < `SDC_FUNC_COUNT; i = i + 1) begin
                shadowA[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                shadowB[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                actA[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
                actB[i] <= funcDefault(i[12:0] + `SDC_ADDR_FUNC_FIRST);
            end
        end else begin
            if (commit_reg) begin
                for (i = 0; i < `SDC_FUNC_COUNT; i = i + 1) begin
                    actA[i] <= shadowA[i];
                    actB[i] <= shadowB[i];
                end
            end
            commit_reg <= 1'b0;
            if (wrStrobe) begin
                if (addr_reg == `SDC_ADDR_PORT_CFG) begin
                    // only honoured with every channel selected
                    if (chanSel_reg[`SDC_SEL_A] && chanSel_reg[`SDC_SEL_B]) begin
                        lsbFirst_reg <= rxByte[`SDC_CFG_LSB_HI] | rxByte[`SDC_CFG_LSB_LO];
                        softRst_reg <= rxByte[`SDC_CFG_SRST_HI] | rxByte[`SDC_CFG_SRST_LO];
                    end
                end else if (addr_reg == `SDC_ADDR_CHAN_SEL) begin
                    chanSel_reg <= rxByte;
                end else if (addr_reg == `SDC_ADDR_COMMIT) begin
                    if (rxByte[`SDC_COMMIT_BIT])
                        commit_reg <= 1'b1;
                end else if (isFunc(addr_reg)) begin
                    // writes land in the shadow only
                    if (addr_reg == `SDC_ADDR_FUNC_GLOBAL) begin
                        shadowA[funcIdx(addr_reg)] <= rxByte;
                        shadowB[funcIdx(addr_reg)] <= rxByte;
                    end else begin
                        if (chanSel_reg[`SDC_SEL_A])
                            shadowA[funcIdx(addr_reg)] <= rxByte;
                        if (chanSel_reg[`SDC_SEL_B])
                            shadowB[funcIdx(addr_reg)] <= rxByte;
                    end
                end
            end
        end
    end

    // ======================================================
    // active copies leave straight from their flops
    generate
        for (g = 0; g < `SDC_FUNC_COUNT; g = g + 1) begin : gOut
            assign activeA[8*g+7:8*g] = actA[g];
            assign activeB[8*g+7:8*g] = actB[g];
        end
    endgenerate
endmodule

// File: rtl/sdc_regs.vh
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// ==========================================================
// register addresses (13-bit address field of the instruction)
`define SDC_ADDR_PORT_CFG 13'h0000
`define SDC_ADDR_DEVICE_IDENTIFIER 13'h0001
`define SDC_ADDR_CHAN_SEL 13'h0005
`define SDC_ADDR_COMMIT 13'h00FF
`define SDC_ADDR_FUNC_FIRST 13'h0008
`define SDC_ADDR_FUNC_LAST 13'h003E
`define SDC_ADDR_FUNC_GLOBAL 13'h000B
`define SDC_ADDR_SHUFFLE 13'h000C

// ==========================================================
// sizes
`define SDC_FUNC_COUNT 55
`define SDC_INSTR_LAST 5'h0F
`define SDC_BYTE_LAST 5'h07

// ==========================================================
// reset values
`define SDC_PORT_CFG_RESET 8'h18
`define SDC_CHAN_SEL_RESET 8'hCF
`define SDC_FUNC_RESET 8'h00
`define SDC_SHUFFLE_RESET 8'h01
`define SDC_COMMIT_VALUE 8'h01

// ==========================================================
// field positions
`define SDC_CFG_LSB_HI 6
`define SDC_CFG_LSB_LO 1
`define SDC_CFG_SRST_HI 5
`define SDC_CFG_SRST_LO 2
`define SDC_CFG_FIXED_MASK 8'h18
`define SDC_SEL_A 0
`define SDC_SEL_B 1
`define SDC_COMMIT_BIT 0
`define SDC_INSTR_RW 15

`endif

// File: rtl/sdc_sync.v
`timescale 1ns/1ps

// ==========================================================
// two-flop synchroniser for pin inputs
module sdc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rstn,
    input wire [WIDTH-1:0] dIn,
    output reg [WIDTH-1:0] dOut
);
    reg [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= RESET_VAL;
            dOut <= RESET_VAL;
        end else begin
            meta_reg <= dIn;
            dOut <= meta_reg;
        end
    end
endmodule

// File: verif/sdc_checker.sv
`timescale 1ns/1ps
`include "sdc_regs.vh"

// ====
// port checks
module sdc_checker (
    input wire clk,
    input wire rstn,
    input wire spiSclk,
    input wire spiCsN,
    input wire sdioIn,
    input wire sdioOut,
    input wire sdioOe,
    input wire lsbFirst_reg,
    input wire [7:0] chanSel_reg,
    input wire [8*`SDC_FUNC_COUNT-1:0] activeA,
    input wire [8*`SDC_FUNC_COUNT-1:0] activeB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // six idle cycles leave margin for the two-flop sync
    property p_rst; $rose(rstn) |-> chanSel_reg == 8'hCF && activeA[39:32] == 8'h01; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_idle_act; spiCsN [*6] |=> $stable(activeA) && $stable(activeB); endproperty
    a_idle_act: assert property (p_idle_act) else $error("active moved");
    property p_idle_cfg; spiCsN [*6] |=> $stable(chanSel_reg) && $stable(lsbFirst_reg); endproperty
    a_idle_cfg: assert property (p_idle_cfg) else $error("config moved");
    property p_once; $changed(activeA) || $changed(activeB) |=> !$changed(activeA) [*3];
    endproperty
    a_once: assert property (p_once) else $error("repeat transfer");
    property p_gate; $changed(lsbFirst_reg) |-> $past(chanSel_reg[0]) && $past(chanSel_reg[1]);
    endproperty
    a_gate: assert property (p_gate) else $error("config ungated");
    property p_glob; activeA[31:24] == activeB[31:24]; endproperty
    a_glob: assert property (p_glob) else $error("global differs");
    property p_oe_off; spiCsN [*5] |-> !sdioOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe after frame");
    property p_oe_on; $rose(sdioOe) |-> !spiCsN && !$past(spiSclk, 2); endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe timing");
    property p_bit; sdioOe && $changed(sdioOut) |-> !$past(spiSclk, 2); endproperty
    a_bit: assert property (p_bit) else $error("bit timing");
    c_read: cover property ($rose(sdioOe));
    c_xfer: cover property ($changed(activeB));
    c_lsb: cover property ($fell(lsbFirst_reg));
endmodule

bind sdc_spi_regs sdc_checker u_sdc_checker (.clk(clk), .rstn(rstn), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .lsbFirst_reg(lsbFirst_reg), .chanSel_reg(chanSel_reg), .activeA(activeA),
    .activeB(activeB));

// File: verif/sdc_host.sv
`timescale 1ns/1ps

// ====
// serial host, drives on sclk fall
module sdc_host (
    input wire clk,
    input wire sdio,
    output reg spiSclk,
    output reg spiCsN,
    output reg hostBit,
    output reg hostOe
);
    reg lsbMode;
    // deselected, clock parked low
    initial {lsbMode, spiSclk, spiCsN, hostBit, hostOe} = 5'h05;
    // one instruction and nb bytes a frame
    task xfer(input rd, input [12:0] a, input [15:0] wd, input integer nb,
        output [15:0] rdat);
        reg [15:0] ins;
        integer i;
        integer k;
        begin
            ins = {rd, 2'b00, a};
            rdat = 16'h0000;
            @(negedge clk);
            spiCsN = 1'b0;
            // instruction then nb streamed bytes, first byte in bits 7:0
            for (i = 0; i < 16 + 8 * nb; i = i + 1) begin
                if (i < 16)
                    k = lsbMode ? i : 15 - i;
                else
                    k = 8 * ((i - 16) / 8) + (lsbMode ? (i - 16) % 8 : 7 - (i - 16) % 8);
                if (i < 16) hostBit = ins[k];
                else if (rd) hostOe = 1'b0;
                else hostBit = wd[k];
                repeat (4) @(negedge clk);
                spiSclk = 1'b1;
                if (i > 15 && rd) rdat[k] = sdio;
                repeat (4) @(negedge clk);
                spiSclk = 1'b0;
            end
            // margin so the byte lands before deselect
            repeat (8) @(negedge clk);
            spiCsN = 1'b1;
            hostOe = 1'b1;
            // deselect gap long enough for the idle checks to engage
            repeat (8) @(negedge clk);
        end
    endtask
endmodule

// File: verif/tb_sdc_spi_regs.sv
`timescale 1ns/1ps
`include "sdc_regs.vh"

// ====
// bench
module tb_sdc_spi_regs;
    localparam [7:0] ID = 8'h3C; // arbitrary value
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg tog = 1'b0;
    reg [15:0] rdat;
    integer error_cnt = 0;
    integer checks_done = 0;
    integer cycles = 0;
    wire spiSclk, spiCsN, sdioIn, sdioOut, sdioOe, hostBit, hostOe, lsbFirst_reg;
    wire [7:0] chanSel_reg;
    wire [8*`SDC_FUNC_COUNT-1:0] activeA, activeB;
    // released pin toggles so stale bits never pass
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : tog);
    always #50 clk = ~clk;
    sdc_spi_regs #(.DEVICE_IDENTIFIER(ID)) u_sdc_spi_regs (.clk(clk), .rstn(rstn), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .lsbFirst_reg(lsbFirst_reg), .chanSel_reg(chanSel_reg), .activeA(activeA),
        .activeB(activeB));
    sdc_host u_sdc_host (.clk(clk), .sdio(sdioIn), .spiSclk(spiSclk), .spiCsN(spiCsN),
        .hostBit(hostBit), .hostOe(hostOe));
    // ceiling well above the 6064-cycle run
    always @(negedge clk) begin
        tog <= ~tog;
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [12:0] a, input [7:0] d);
        u_sdc_host.xfer(1'b0, a, {8'h00, d}, 1, rdat);
    endtask
    task rd(input [12:0] a, input [7:0] e);
        begin
            u_sdc_host.xfer(1'b1, a, 16'h0000, 1, rdat);
            cmp(rdat[7:0], e);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // reset, defaults, shadowing, channels, port config
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        rd(13'h000, 8'h18);
        rd(13'h005, 8'hCF);
        rd(13'h00C, 8'h01);
        rd(13'h013, 8'h00);
        wr(13'h001, 8'hFF);
        rd(13'h001, ID);
        wr(13'h005, 8'h01);
        wr(13'h00D, 8'h11);
        wr(13'h00B, 8'h05);
        wr(13'h005, 8'h02);
        wr(13'h00D, 8'h22);
        wr(13'h005, 8'h03);
        wr(13'h008, 8'h03);
        cmp(activeA[8*5 +: 8], 8'h00);
        wr(13'h0FF, 8'h01);
        cmp(activeA[8*5 +: 8], 8'h11);
        cmp(activeB[8*5 +: 8], 8'h22);
        cmp(activeB[7:0], 8'h03);
        cmp(activeB[31:24], 8'h05);
        rd(13'h0FF, 8'h00);
        rd(13'h00D, 8'h11);
        wr(13'h005, 8'h02);
        rd(13'h00D, 8'h22);
        rd(13'h00B, 8'h05);
        // streaming msb-first walks the address down: 0x0E then 0x0D
        u_sdc_host.xfer(1'b0, 13'h00E, 16'h4433, 2, rdat);
        u_sdc_host.xfer(1'b1, 13'h00E, 16'h0000, 2, rdat);
        cmp(rdat[7:0], 8'h33);
        cmp(rdat[15:8], 8'h44);
        wr(13'h000, 8'h5A);
        cmp({7'h00, lsbFirst_reg}, 8'h00);
        wr(13'h005, 8'hCF);
        wr(13'h000, 8'h5A);
        cmp({7'h00, lsbFirst_reg}, 8'h01);
        u_sdc_host.lsbMode = 1'b1;
        rd(13'h000, 8'h5A);
        // streaming lsb-first walks the address up: 0x00 then 0x01
        u_sdc_host.xfer(1'b1, 13'h000, 16'h0000, 2, rdat);
        cmp(rdat[7:0], 8'h5A);
        cmp(rdat[15:8], ID);
        wr(13'h000, 8'h3C);
        u_sdc_host.lsbMode = 1'b0;
        cmp(activeA[8*5 +: 8], 8'h00);
        rd(13'h005, 8'hCF);
        conclude;
    end
endmodule
